// [ptp_regs.sv]
// timing scale, configuration and pushbutton register bank on AHB-Lite
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ptp_regs #(
    parameter int         PORTS         = 4,
    parameter int         START_NOM_CYC = ptp_pkg::START_NOM_CYC,
    parameter int         FAULT_NOM_CYC = ptp_pkg::FAULT_NOM_CYC,
    parameter int         DISC_NOM_CYC  = ptp_pkg::DISC_NOM_CYC,
    parameter logic [4:0] PART_ID       = 5'h05,  // arbitrary value
    parameter logic [2:0] SILICON_REV   = 3'h1    // arbitrary value
) (
    input  wire logic                    mclk,
    input  wire logic                    arst_n,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // port state machines
    input  wire ptp_pkg::ptp_port_stat_t portStat [PORTS],
    output ptp_pkg::ptp_port_cmd_t       portCmd [PORTS],
    // event block
    input  wire logic                    eventPending,
    output logic                         clearEvents,
    output logic                         chipSoftReset,
    // timers
    output logic      [31:0]             startTimeCycles,
    output logic      [31:0]             faultTimeCycles,
    output logic      [31:0]             discTimeCycles,
    output logic      [31:0]             restartTimeCycles,
    // pins
    output logic                         detectSenseIsolate,
    output logic                         intOut,
    output logic                         intOe_n
);

    // elaboration checks
    if (PORTS != 4) begin : g_bad_ports
        $error("ptp_regs serves exactly four ports");
    end
    if (FAULT_NOM_CYC < 1 || START_NOM_CYC < 1 || DISC_NOM_CYC < 4
            || FAULT_NOM_CYC > 16_000_000 || START_NOM_CYC > 1_000_000_000
            || DISC_NOM_CYC > 2_000_000_000) begin : g_bad_time
        $error("ptp_regs nominal cycle counts out of range");
    end

    // registers
    logic [7:0]  timingScale;
    logic [7:0]  miscCfg;
    logic [7:0]  pwrBtn;
    logic [7:0]  globalBtn;
    logic [31:0] holdoffCnt [PORTS];

    // bus address phase capture
    logic        wrPend;
    logic [7:0]  wrIdx;
    logic        addrPhase;
    logic        addrOk;
    logic [7:0]  addrIdx;
    logic        wrTiming;
    logic        wrMisc;
    logic        wrPwr;
    logic        wrGlobal;
    logic        softRst;

    assign addrPhase = hsel & hready & htrans[1];
    // word aligned, inside the bank's window
    assign addrOk    = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign addrIdx   = haddr[9:2];

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // writes land in the data phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend <= 1'b0;
            wrIdx  <= 8'h00;
        end else begin
            wrPend <= addrPhase & hwrite & addrOk;
            wrIdx  <= addrIdx;
        end
    end

    assign wrTiming = wrPend && (wrIdx == ptp_pkg::IDX_TIMING);
    assign wrMisc   = wrPend && (wrIdx == ptp_pkg::IDX_MISC);
    assign wrPwr    = wrPend && (wrIdx == ptp_pkg::IDX_PWRBTN);
    assign wrGlobal = wrPend && (wrIdx == ptp_pkg::IDX_GLOBAL);

    // chip soft reset acts the cycle after its bit is latched
    assign softRst = globalBtn[ptp_pkg::GLB_CHIP_RST];

    // read data registered at the address phase; unmapped reads as zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (addrOk) begin
                unique case (addrIdx)
                    ptp_pkg::IDX_TIMING: hrdata[7:0] <= timingScale;
                    ptp_pkg::IDX_MISC:   hrdata[7:0] <= miscCfg;
                    ptp_pkg::IDX_PWRBTN: hrdata[7:0] <= pwrBtn;
                    ptp_pkg::IDX_GLOBAL: hrdata[7:0] <= globalBtn;
                    ptp_pkg::IDX_IDENT:  hrdata[7:0] <= {PART_ID, SILICON_REV};
                    default:             hrdata[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // timing scale register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            timingScale <= ptp_pkg::RST_TIMING;
        end else if (softRst) begin
            timingScale <= ptp_pkg::RST_TIMING;
        end else if (wrTiming) begin
            timingScale <= hwdata[7:0];
        end
    end

    // configuration register; reserved bits stay zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            miscCfg <= ptp_pkg::RST_MISC;
        end else if (softRst) begin
            miscCfg <= ptp_pkg::RST_MISC;
        end else if (wrMisc) begin
            miscCfg <= hwdata[7:0] & ptp_pkg::MISC_WMASK;
        end
    end

    // scale a nominal count by a field code: 1, 1/2, 2, 4
    function automatic logic [31:0] scaleRun(input logic [31:0] nom, input logic [1:0] code);
        unique case (code)
            2'b00: scaleRun = nom;
            2'b01: scaleRun = nom >> 1;
            2'b10: scaleRun = nom << 1;
            2'b11: scaleRun = nom << 2;
        endcase
    endfunction

    // disconnect scale: 1, 1/4, 1/2, 2
    function automatic logic [31:0] scaleDisc(input logic [31:0] nom, input logic [1:0] code);
        unique case (code)
            2'b00: scaleDisc = nom;
            2'b01: scaleDisc = nom >> 2;
            2'b10: scaleDisc = nom >> 1;
            2'b11: scaleDisc = nom << 1;
        endcase
    endfunction

    // restart multiplier per field code
    function automatic logic [6:0] restartMult(input logic [1:0] code);
        unique case (code)
            2'b00: restartMult = ptp_pkg::RESTART_MULT_00;
            2'b01: restartMult = ptp_pkg::RESTART_MULT_01;
            2'b10: restartMult = ptp_pkg::RESTART_MULT_10;
            2'b11: restartMult = ptp_pkg::RESTART_MULT_11;
        endcase
    endfunction

    logic [63:0] restartProd;

    // scaled times registered so the port timers see stable counts
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            startTimeCycles <= 32'h0000_0000;
            faultTimeCycles <= 32'h0000_0000;
            discTimeCycles  <= 32'h0000_0000;
        end else begin
            startTimeCycles <= scaleRun(32'(START_NOM_CYC),
                                        timingScale[ptp_pkg::START_LSB +: 2]);
            faultTimeCycles <= scaleRun(32'(FAULT_NOM_CYC),
                                        timingScale[ptp_pkg::FAULT_LSB +: 2]);
            discTimeCycles  <= scaleDisc(32'(DISC_NOM_CYC),
                                         timingScale[ptp_pkg::DISC_LSB +: 2]);
        end
    end

    // off time follows the scaled fault time
    assign restartProd = 64'(faultTimeCycles) *
                         64'(restartMult(timingScale[ptp_pkg::RESTART_LSB +: 2]));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            restartTimeCycles <= 32'h0000_0000;
        end else begin
            restartTimeCycles <= restartProd[31:0];
        end
    end

    // per-port request qualification
    logic [PORTS-1:0] upOk;
    logic [PORTS-1:0] downOk;
    logic [PORTS-1:0] held;

    // power pushbuttons: set by writes, cleared when taken or ignored
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pwrBtn <= ptp_pkg::RST_PWRBTN;
        end else if (softRst) begin
            pwrBtn <= ptp_pkg::RST_PWRBTN;
        end else begin
            // pending bits are acted on in one cycle, so a new write wins
            pwrBtn <= wrPwr ? hwdata[7:0] : 8'h00;
        end
    end

    // global pushbuttons; port resets and clear execute in one cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            globalBtn <= ptp_pkg::RST_GLOBAL;
        end else if (softRst) begin
            globalBtn <= ptp_pkg::RST_GLOBAL;
        end else begin
            globalBtn <= wrGlobal ? (hwdata[7:0] & 8'h9F) : 8'h00;
        end
    end

    // single-cycle global actions
    assign clearEvents   = globalBtn[ptp_pkg::GLB_CLR_EVENTS];
    assign chipSoftReset = softRst;

    // per-port command generation and restart holdoff
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        logic [1:0] mode;
        logic       autoMode;
        logic       shut;

        assign mode     = portStat[p].mode;
        assign autoMode = (mode == ptp_pkg::MODE_AUTO);
        assign shut     = (mode == ptp_pkg::MODE_SHUTDOWN);

        // holdoff counter reloads on every overcurrent shutdown except in a chip soft reset cycle, which clears it
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                holdoffCnt[p] <= 32'h0000_0000;
            end else if (softRst) begin
                holdoffCnt[p] <= 32'h0000_0000;
            end else if (portStat[p].ocShutdown) begin
                // a fresh shutdown wins over a port reset in the same cycle
                holdoffCnt[p] <= restartTimeCycles;
            end else if (globalBtn[p]) begin
                holdoffCnt[p] <= 32'h0000_0000;
            end else if (holdoffCnt[p] != 32'h0000_0000) begin
                holdoffCnt[p] <= holdoffCnt[p] - 32'h0000_0001;
            end
        end

        // holdoff only matters while enabled; disabling releases at once
        assign held[p] = miscCfg[ptp_pkg::MISC_HOLDOFF]
                         && (holdoffCnt[p] != 32'h0000_0000);

        // ignore redundant, shutdown-mode and auto-mode power-up
        assign upOk[p]   = pwrBtn[p] && !portStat[p].powered && !shut
                           && !autoMode && !held[p];
        assign downOk[p] = pwrBtn[p+4] && portStat[p].powered && !shut;

        // commands are one-cycle pulses, except the steady levels
        always_comb begin
            portCmd[p].powerUp      = upOk[p] && !downOk[p];
            portCmd[p].powerDown    = downOk[p] || globalBtn[p];
            portCmd[p].abortDetect  = upOk[p] && !downOk[p]
                                      && portStat[p].detClass;
            portCmd[p].softReset    = globalBtn[p];
            portCmd[p].reducedLimit = miscCfg[ptp_pkg::MISC_CLSGUARD];
            portCmd[p].highCurrent  = portStat[p].powerGood;
            portCmd[p].powerBlock   = held[p]
                                      || (miscCfg[ptp_pkg::MISC_CLASSBLK] && autoMode
                                          && portStat[p].classFail);
        end
    end

    // detect sense pin isolation has no other side effect
    assign detectSenseIsolate = miscCfg[ptp_pkg::MISC_DETISO];

    // open-drain interrupt pin, pulled low while driven
    logic intDrive;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            intDrive <= 1'b0;
        end else begin
            intDrive <= eventPending && miscCfg[ptp_pkg::MISC_INT_EN]
                        && !clearEvents;
        end
    end

    assign intOut  = 1'b0;
    assign intOe_n = ~intDrive;

endmodule  // ptp_regs

`default_nettype wire

// [ptp_pkg.sv]
// package: register map, reset values and port-side carriers for the timing/pushbutton bank
package ptp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMING = 8'h16;
    localparam logic [7:0] IDX_MISC   = 8'h17;
    localparam logic [7:0] IDX_PWRBTN = 8'h19;
    localparam logic [7:0] IDX_GLOBAL = 8'h1A;
    localparam logic [7:0] IDX_IDENT  = 8'h1B;

    // reset values
    localparam logic [7:0] RST_TIMING = 8'h00;
    localparam logic [7:0] RST_MISC   = 8'hC0;
    localparam logic [7:0] RST_PWRBTN = 8'h00;
    localparam logic [7:0] RST_GLOBAL = 8'h00;

    // writable bits of the miscellaneous configuration register
    localparam logic [7:0] MISC_WMASK = 8'hCE;

    // timing register field positions
    localparam int RESTART_LSB = 6;
    localparam int START_LSB   = 4;
    localparam int FAULT_LSB   = 2;
    localparam int DISC_LSB    = 0;

    // misc configuration bit positions
    localparam int MISC_INT_EN    = 7;
    localparam int MISC_HOLDOFF   = 6;
    localparam int MISC_CLASSBLK  = 3;
    localparam int MISC_CLSGUARD  = 2;
    localparam int MISC_DETISO    = 1;

    // global pushbutton bit positions
    localparam int GLB_CLR_EVENTS = 7;
    localparam int GLB_CHIP_RST   = 4;

    // restart off time as multiples of fault time, per field code
    localparam logic [6:0] RESTART_MULT_00 = 7'd16;
    localparam logic [6:0] RESTART_MULT_01 = 7'd32;
    localparam logic [6:0] RESTART_MULT_10 = 7'd64;
    localparam logic [6:0] RESTART_MULT_11 = 7'd0;

    // nominal times and the clock rate
    localparam int CLK_KHZ      = 100_000;
    localparam int START_NOM_MS = 60;
    localparam int FAULT_NOM_MS = 60;
    localparam int DISC_NOM_MS  = 350;
    localparam int START_NOM_CYC = START_NOM_MS * CLK_KHZ;
    localparam int FAULT_NOM_CYC = FAULT_NOM_MS * CLK_KHZ;
    localparam int DISC_NOM_CYC  = DISC_NOM_MS * CLK_KHZ;

    // port operating modes
    localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
    localparam logic [1:0] MODE_MANUAL   = 2'b01;
    localparam logic [1:0] MODE_SEMI     = 2'b10;
    localparam logic [1:0] MODE_AUTO     = 2'b11;

    // status from one port state machine
    typedef struct packed {
        logic [1:0] mode;        // operating mode of the port
        logic       powered;     // power switch on
        logic       powerGood;   // startup finished successfully
        logic       detClass;    // detection or classification in progress
        logic       classFail;   // classification current above limit
        logic       ocShutdown;  // pulse: shut down for extended overcurrent
    } ptp_port_stat_t;

    // commands to one port state machine
    typedef struct packed {
        logic powerUp;           // pulse: turn power on
        logic powerDown;         // pulse: turn power off
        logic abortDetect;       // pulse: end detection/classification first
        logic softReset;         // pulse: power off, clear status and events
        logic reducedLimit;      // lower overcurrent threshold by class
        logic highCurrent;       // high-power current setting allowed
        logic powerBlock;        // refuse power-on
    } ptp_port_cmd_t;

endpackage

// [ptp_regs_sva.sv]
// assertion checker on the pins of the timing and pushbutton register bank
`timescale 1ns/1ps
`default_nettype none
module ptp_regs_sva #(
    parameter int PORTS         = 4,
    parameter int FAULT_NOM_CYC = 40
) (
    input wire logic                    mclk,
    input wire logic                    arst_n,
    input wire logic [31:0]             hrdata,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire ptp_pkg::ptp_port_stat_t portStat [PORTS],
    input wire ptp_pkg::ptp_port_cmd_t  portCmd [PORTS],
    input wire logic                    clearEvents,
    input wire logic                    eventPending,
    input wire logic                    chipSoftReset,
    input wire logic [31:0]             faultTimeCycles,
    input wire logic                    intOut,
    input wire logic                    intOe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic upAuto, upBad, downBad, hcBad, upBlocked, abortBad;
    // per-port faults folded into flags so one property covers all ports
    always_comb begin
        {upAuto, upBad, downBad, hcBad, upBlocked, abortBad} = 6'h00;
        for (int p = 0; p < PORTS; p++) begin
            if (portCmd[p].powerUp && portStat[p].mode == ptp_pkg::MODE_AUTO) upAuto = 1'b1;
            if (portCmd[p].powerUp && portStat[p].powered) upBad = 1'b1;
            if (portCmd[p].powerUp && portStat[p].mode == ptp_pkg::MODE_SHUTDOWN) upBad = 1'b1;
            if (portCmd[p].powerDown && !portCmd[p].softReset &&
                (!portStat[p].powered || portStat[p].mode == ptp_pkg::MODE_SHUTDOWN)) downBad = 1'b1;
            if (portCmd[p].highCurrent && !portStat[p].powerGood) hcBad = 1'b1;
            if (portCmd[p].powerUp && portCmd[p].powerBlock) upBlocked = 1'b1;
            if (portCmd[p].abortDetect && !portStat[p].detClass) abortBad = 1'b1;
        end
    end
    sequence s_nominal;
        faultTimeCycles == FAULT_NOM_CYC;
    endsequence
    property p_bus_okay; hreadyout && !hresp && hrdata[31:8] == 24'h00_0000; endproperty
    property p_int_cause; $fell(intOe_n) |-> $past(eventPending) && !intOut; endproperty
    property p_up_auto; !upAuto; endproperty
    property p_redundant; !upBad && !downBad; endproperty
    property p_high_current; !hcBad; endproperty
    property p_up_pulse; portCmd[0].powerUp |=> !portCmd[0].powerUp; endproperty
    property p_block_up; !upBlocked; endproperty
    property p_chip_rst; chipSoftReset |-> ##[1:4] s_nominal; endproperty
    property p_abort; !abortBad; endproperty
    property p_clr_pulse; clearEvents |=> !clearEvents; endproperty
    a_bus_okay:     assert property (p_bus_okay) else $error("bus answer not zero-wait okay");
    a_int_cause:    assert property (p_int_cause) else $error("interrupt without event");
    a_up_auto:      assert property (p_up_auto) else $error("power up in auto mode");
    a_redundant:    assert property (p_redundant) else $error("redundant button acted");
    a_high_current: assert property (p_high_current) else $error("high current early");
    a_up_pulse:     assert property (p_up_pulse) else $error("power up button stuck");
    a_block_up:     assert property (p_block_up) else $error("power up in holdoff");
    a_chip_rst:     assert property (p_chip_rst) else $error("timing not reset");
    a_abort:        assert property (p_abort) else $error("abort outside detection");
    a_clr_pulse:    assert property (p_clr_pulse) else $error("clear events stuck");
endmodule // ptp_regs_sva
bind ptp_regs ptp_regs_sva #(.PORTS(PORTS), .FAULT_NOM_CYC(FAULT_NOM_CYC)) ptp_regs_sva_i (
    .mclk(mclk), .arst_n(arst_n), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .portStat(portStat), .portCmd(portCmd), .clearEvents(clearEvents),
    .chipSoftReset(chipSoftReset), .faultTimeCycles(faultTimeCycles), .intOut(intOut),
    .intOe_n(intOe_n), .eventPending(eventPending));
`default_nettype wire

// [ptp_host_model.sv]
// host controller model issuing single word bus transfers
`timescale 1ns/1ps
`default_nettype none
module ptp_host_model (
    input  wire logic        mclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // idle bus from time zero so no request is seen during reset
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end
    // address phase held until ready, then data phase held until ready
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {22'h00_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic write(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] unused;
        xfer(idx, 1'b1, wd, unused);
    endtask
    task automatic read(input logic [7:0] idx, output logic [31:0] rd);
        xfer(idx, 1'b0, 8'h00, rd);
    endtask
endmodule // ptp_host_model
`default_nettype wire

// [ptp_regs_bench.sv]
// self-checking bench for the timing and pushbutton register bank
`timescale 1ns/1ps
`default_nettype none
module ptp_regs_bench;
    // short nominal times keep the run brief
    localparam int         SC   = 40;
    localparam int         FC   = 40;
    localparam int         DC   = 80;
    localparam logic [4:0] PID  = 5'h0A;  // arbitrary value
    localparam logic [2:0] PREV = 3'h2;   // arbitrary value
    logic                    mclk, arst_n, hsel, hwrite, hreadyout, hresp, eventPending;
    logic                    clearEvents, chipSoftReset, detectSenseIsolate, intOut, intOe_n;
    logic [1:0]              htrans;
    logic [2:0]              hsize;
    logic [31:0]             haddr, hwdata, hrdata, startT, faultT, discT, restartT;
    ptp_pkg::ptp_port_stat_t portStat [4];
    ptp_pkg::ptp_port_cmd_t  portCmd [4];
    int                      failures = 0;
    int                      samplesChecked = 0;
    int                      upCnt [4] = '{default: 0};
    int                      downCnt [4] = '{default: 0};
    int                      rstCnt [4] = '{default: 0};
    int                      abortCnt = 0;
    int                      clrCnt = 0;
    int                      mult [4] = '{16, 32, 64, 0};
    ptp_regs #(.START_NOM_CYC(SC), .FAULT_NOM_CYC(FC), .DISC_NOM_CYC(DC),
               .PART_ID(PID), .SILICON_REV(PREV)) ptp_regs_i (
        .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .portStat(portStat),
        .portCmd(portCmd), .eventPending(eventPending), .clearEvents(clearEvents),
        .chipSoftReset(chipSoftReset), .startTimeCycles(startT), .faultTimeCycles(faultT),
        .discTimeCycles(discT), .restartTimeCycles(restartT),
        .detectSenseIsolate(detectSenseIsolate), .intOut(intOut), .intOe_n(intOe_n));
    ptp_host_model ptp_host_model_i (
        .mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // pulse counters; command lines are settled at each rising edge
    always @(posedge mclk) begin
        for (int p = 0; p < 4; p++) begin
            upCnt[p] += portCmd[p].powerUp;
            downCnt[p] += portCmd[p].powerDown;
            rstCnt[p] += portCmd[p].softReset;
            abortCnt += portCmd[p].abortDetect;
        end
        clrCnt += clearEvents;
    end
    // disconnect scale differs from the startup and fault scale
    function automatic int scl(input int nom, input logic [1:0] c, input bit disc);
        if (disc) return c == 0 ? nom : c == 1 ? nom / 4 : c == 2 ? nom / 2 : nom * 2;
        return c == 0 ? nom : c == 1 ? nom / 2 : c == 2 ? nom * 2 : nom * 4;
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdChk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        ptp_host_model_i.read(idx, v);
        check(what, exp, v);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        idle(4000);
        failures++;
        give_verdict();
    end
    initial begin
        arst_n = 1'b0;
        eventPending = 1'b0;
        // manual detecting, auto class-failed, shutdown powered, semi powered and good
        portStat[0] = '{ptp_pkg::MODE_MANUAL, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        portStat[1] = '{ptp_pkg::MODE_AUTO, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        portStat[2] = '{ptp_pkg::MODE_SHUTDOWN, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        portStat[3] = '{ptp_pkg::MODE_SEMI, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        idle(5);
        arst_n <= 1'b1;
        ptp_host_model_i.write(8'h30, 8'hFF);
        rdChk("misc", ptp_pkg::IDX_MISC, 32'h0000_00C0);
        rdChk("timing", ptp_pkg::IDX_TIMING, 32'h0000_0000);
        rdChk("powerButtons", ptp_pkg::IDX_PWRBTN, 32'h0000_0000);
        rdChk("globalButtons", ptp_pkg::IDX_GLOBAL, 32'h0000_0000);
        rdChk("identity", ptp_pkg::IDX_IDENT, {24'h00_0000, PID, PREV});
        rdChk("hole", 8'h30, 32'h0000_0000);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            ptp_host_model_i.write(ptp_pkg::IDX_TIMING, {4{c[1:0]}});
            idle(3);
            check("startTime", scl(SC, c[1:0], 1'b0), startT);
            check("faultTime", scl(FC, c[1:0], 1'b0), faultT);
            check("discTime", scl(DC, c[1:0], 1'b1), discT);
            check("restartTime", mult[c] * scl(FC, c[1:0], 1'b0), restartT);
        end
        $display("timing test done");
        ptp_host_model_i.write(ptp_pkg::IDX_MISC, 8'hFF);
        rdChk("miscMask", ptp_pkg::IDX_MISC, {24'h00_0000, ptp_pkg::MISC_WMASK});
        check("isolate", 1, detectSenseIsolate);
        check("reducedLimit", 1, portCmd[2].reducedLimit);
        check("classBlock", 1, portCmd[1].powerBlock);
        check("highCurrent", 1, portCmd[3].highCurrent);
        ptp_host_model_i.write(ptp_pkg::IDX_MISC, 8'h00);
        eventPending <= 1'b1;
        idle(3);
        check("isolateOff", 0, detectSenseIsolate);
        check("reducedOff", 0, portCmd[2].reducedLimit);
        check("intMasked", 1, intOe_n);
        ptp_host_model_i.write(ptp_pkg::IDX_MISC, 8'h80);
        idle(2);
        check("intDriven", 0, intOe_n);
        check("intLevel", 0, intOut);
        ptp_host_model_i.write(ptp_pkg::IDX_GLOBAL, 8'h80);
        idle(2);
        check("intCleared", 1, intOe_n);
        eventPending <= 1'b0;
        idle(3);
        check("clearEvents", 1, clrCnt);
        check("intReleased", 1, intOe_n);
        $display("config test done");
        ptp_host_model_i.write(ptp_pkg::IDX_PWRBTN, 8'h0F);
        idle(3);
        ptp_host_model_i.write(ptp_pkg::IDX_PWRBTN, 8'hF0);
        idle(3);
        rdChk("buttonsClear", ptp_pkg::IDX_PWRBTN, 32'h0000_0000);
        for (int p = 0; p < 4; p++) begin
            check("powerUp", p == 0, upCnt[p]);
            check("powerDown", p == 3, downCnt[p]);
        end
        check("abortDetect", 1, abortCnt);
        ptp_host_model_i.write(ptp_pkg::IDX_GLOBAL, 8'h0A);
        idle(3);
        rdChk("globalClear", ptp_pkg::IDX_GLOBAL, 32'h0000_0000);
        for (int p = 0; p < 4; p++) begin
            check("softReset", p == 1 || p == 3, rstCnt[p]);
        end
        $display("button test done");
        ptp_host_model_i.write(ptp_pkg::IDX_TIMING, 8'h00);
        ptp_host_model_i.write(ptp_pkg::IDX_MISC, 8'hC0);
        portStat[0].ocShutdown <= 1'b1;
        idle(1);
        portStat[0].ocShutdown <= 1'b0;
        idle(3);
        check("holdoff", 1, portCmd[0].powerBlock);
        ptp_host_model_i.write(ptp_pkg::IDX_PWRBTN, 8'h01);
        idle(3);
        check("blockedUp", 1, upCnt[0]);
        idle(16 * FC - 30);
        check("holdoffHeld", 1, portCmd[0].powerBlock);
        idle(30);
        check("holdoffEnd", 0, portCmd[0].powerBlock);
        ptp_host_model_i.write(ptp_pkg::IDX_PWRBTN, 8'h01);
        idle(3);
        check("freedUp", 2, upCnt[0]);
        $display("holdoff test done");
        ptp_host_model_i.write(ptp_pkg::IDX_TIMING, 8'hFF);
        ptp_host_model_i.write(ptp_pkg::IDX_MISC, 8'h0E);
        ptp_host_model_i.write(ptp_pkg::IDX_GLOBAL, 8'h10);
        idle(3);
        rdChk("timingReset", ptp_pkg::IDX_TIMING, 32'h0000_0000);
        rdChk("miscReset", ptp_pkg::IDX_MISC, 32'h0000_00C0);
        $display("chip reset test done");
        give_verdict();
    end
endmodule // ptp_regs_bench
`default_nettype wire
